// [dtu_map.svh]
// Summary of operation
// [RQ1] immediate load sets working register, flags kept
// [RQ2] memory store writes byte, flags kept
// [RQ3] memory load copies byte, zero flag tracks it
// [RQ4] i/o load copies register, zero flag tracks it
// [RQ5] i/o store writes register, flags kept
// [RQ6] timer count copied into memory word
// [RQ7] timer count loaded from memory word
// [RQ8] indirect read through pointer, two cycles
// [RQ9] software writes pointer low byte first
// [RQ10] software keeps pointer high byte zero
// [RQ11] word operands stay in first 32 bytes
// [RQ12] zero flag is one exactly for zero result
// [RQ13] other transfers finish in one cycle
`ifndef DTU_MAP_SVH
`define DTU_MAP_SVH

`define DTU_MEM_AW      8
`define DTU_IO_AW       6
`define DTU_WORD_SPAN   32
`define DTU_WORD_IDX_W  4
`define DTU_IND_CYCLES  2
`define DTU_ACC_RST     8'h00
`define DTU_PTR_RST     8'h00
`define DTU_ZERO_BYTE   8'h00
`define DTU_WORD_LO_BIT 1'b0
`define DTU_WORD_HI_BIT 1'b1

`endif

// [dtu_pkg.sv]
`include "dtu_map.svh"

package dtu_pkg;

  typedef enum logic [3:0] {
    DTU_OP_NOP     = 4'h0,
    DTU_OP_LD_IMM  = 4'h1,
    DTU_OP_ST_MEM  = 4'h2,
    DTU_OP_LD_MEM  = 4'h3,
    DTU_OP_LD_IO   = 4'h4,
    DTU_OP_ST_IO   = 4'h5,
    DTU_OP_TMR_RD  = 4'h6,
    DTU_OP_TMR_WR  = 4'h7,
    DTU_OP_IND_RD  = 4'h8
  } dtu_op_t;

  typedef enum logic [1:0] {
    DTU_ST_IDLE = 2'b01,
    DTU_ST_IND  = 2'b10
  } dtu_state_t;

  typedef struct packed {
    logic z;
    logic c;
    logic ac;
    logic ov;
  } dtu_flags_t;

  typedef struct packed {
    logic       valid;
    dtu_op_t    op;
    logic [7:0] arg;
  } dtu_instr_t;

  typedef struct packed {
    logic                   we;
    logic [`DTU_IO_AW-1:0]  addr;
    logic [7:0]             data;
  } dtu_io_wr_t;

  typedef struct packed {
    logic        load;
    logic [15:0] value;
  } dtu_tmr_wr_t;

endpackage

// [dtu_flag_unit.sv]
`timescale 1ns/1ps
`include "dtu_map.svh"

module dtu_flag_unit
(
  input  dtu_pkg::dtu_flags_t flags_i,
  input  wire logic           zero_upd_i,
  input  wire logic [7:0]     result_i,
  output dtu_pkg::dtu_flags_t flags_o
);
  import dtu_pkg::*;

  // only the zero flag moves; carry, half carry, overflow held
  always_comb
  begin
    flags_o = flags_i;
    if (zero_upd_i)
    begin
      flags_o.z = (result_i == `DTU_ZERO_BYTE); // RQ12
    end
  end

endmodule

// [dtu_core.sv]
`timescale 1ns/1ps
`include "dtu_map.svh"

module dtu_core #(
  parameter int MEM_AW = `DTU_MEM_AW
)
(
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_i,
  input  dtu_pkg::dtu_instr_t         instr_i,
  input  wire logic [7:0]             io_rdata_i,
  input  wire logic [15:0]            timer_count_i,
  input  wire logic [MEM_AW-1:0]      peek_addr_i,
  output logic [7:0]                  acc_o,
  output dtu_pkg::dtu_flags_t         flags_o,
  output logic                        busy_o,
  output logic                        done_o,
  output dtu_pkg::dtu_io_wr_t         io_wr_o,
  output dtu_pkg::dtu_tmr_wr_t        tmr_wr_o,
  output logic [7:0]                  peek_data_o
);
  import dtu_pkg::*;

  localparam int DEPTH = 2 ** MEM_AW;

  dtu_state_t          state_reg, state_next;
  logic [7:0]          acc_reg, acc_next;
  dtu_flags_t          flags_reg, flags_next;
  logic [MEM_AW-1:0]   ptr_reg, ptr_next;
  logic                busy_reg, busy_next;
  logic                done_reg, done_next;
  dtu_io_wr_t          io_reg, io_next;
  dtu_tmr_wr_t         tmr_reg, tmr_next;
  logic [7:0]          peek_reg, peek_next;
  logic [7:0]          mem_reg [DEPTH];
  logic [7:0]          mem_next [DEPTH];
  logic                wa_en, wb_en;
  logic [MEM_AW-1:0]   wa_addr, wb_addr;
  logic [7:0]          wa_data, wb_data;
  logic                zero_upd;
  logic [7:0]          zero_val;
  logic                take;
  logic [MEM_AW-1:0]   word_lo, word_hi;

  ////////////////////////////////////////////////////////////////////////////
  // instruction sequencing

  assign take = instr_i.valid && (state_reg == DTU_ST_IDLE);
  // word operands confined to the first 32 bytes
  assign word_lo = MEM_AW'({instr_i.arg[`DTU_WORD_IDX_W-1:0],
                            `DTU_WORD_LO_BIT}); // RQ11
  assign word_hi = MEM_AW'({instr_i.arg[`DTU_WORD_IDX_W-1:0],
                            `DTU_WORD_HI_BIT}); // RQ11

  always_comb
  begin
    state_next = state_reg;
    acc_next   = acc_reg;
    ptr_next   = ptr_reg;
    done_next  = 1'b0;
    io_next    = '0;
    tmr_next   = '0;
    zero_upd   = 1'b0;
    zero_val   = `DTU_ZERO_BYTE;
    wa_en      = 1'b0;
    wa_addr    = '0;
    wa_data    = `DTU_ZERO_BYTE;
    wb_en      = 1'b0;
    wb_addr    = '0;
    wb_data    = `DTU_ZERO_BYTE;
    unique case (state_reg)
      DTU_ST_IDLE:
      begin
        if (take)
        begin
          done_next = 1'b1; // RQ13
          unique case (instr_i.op)
            DTU_OP_LD_IMM:
            begin
              acc_next = instr_i.arg; // RQ1
            end
            DTU_OP_ST_MEM:
            begin
              wa_en   = 1'b1; // RQ2
              wa_addr = instr_i.arg[MEM_AW-1:0];
              wa_data = acc_reg;
            end
            DTU_OP_LD_MEM:
            begin
              acc_next = mem_reg[instr_i.arg[MEM_AW-1:0]]; // RQ3
              zero_upd = 1'b1;
              zero_val = acc_next;
            end
            DTU_OP_LD_IO:
            begin
              acc_next = io_rdata_i; // RQ4
              zero_upd = 1'b1;
              zero_val = io_rdata_i;
            end
            DTU_OP_ST_IO:
            begin
              io_next.we   = 1'b1; // RQ5
              io_next.addr = instr_i.arg[`DTU_IO_AW-1:0];
              io_next.data = acc_reg;
            end
            DTU_OP_TMR_RD:
            begin
              wa_en   = 1'b1; // RQ6
              wa_addr = word_lo;
              wa_data = timer_count_i[7:0];
              wb_en   = 1'b1;
              wb_addr = word_hi;
              wb_data = timer_count_i[15:8];
            end
            DTU_OP_TMR_WR:
            begin
              tmr_next.load  = 1'b1; // RQ7
              tmr_next.value = {mem_reg[word_hi], mem_reg[word_lo]};
            end
            DTU_OP_IND_RD:
            begin
              // pointer high byte is ignored
              ptr_next   = mem_reg[word_lo][MEM_AW-1:0]; // RQ8 RQ10
              state_next = DTU_ST_IND;
              done_next  = 1'b0;
            end
            DTU_OP_NOP:
            begin
              done_next = 1'b1;
            end
            default:
            begin
              done_next = 1'b1;
            end
          endcase
        end
      end
      DTU_ST_IND:
      begin
        acc_next   = mem_reg[ptr_reg]; // RQ8
        state_next = DTU_ST_IDLE;
        done_next  = 1'b1;
      end
      default:
      begin
        state_next = DTU_ST_IDLE;
      end
    endcase
    busy_next = (state_next == DTU_ST_IND);
    peek_next = mem_reg[peek_addr_i];
  end

  dtu_flag_unit u_flags
  (
    .flags_i    (flags_reg),
    .zero_upd_i (zero_upd),
    .result_i   (zero_val),
    .flags_o    (flags_next)
  );

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= DTU_ST_IDLE;
      acc_reg   <= `DTU_ACC_RST;
      flags_reg <= '0;
      ptr_reg   <= MEM_AW'(`DTU_PTR_RST);
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      io_reg    <= '0;
      tmr_reg   <= '0;
      peek_reg  <= `DTU_ZERO_BYTE;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      flags_reg <= flags_next;
      ptr_reg   <= ptr_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      io_reg    <= io_next;
      tmr_reg   <= tmr_next;
      peek_reg  <= peek_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_mem
    always_comb
    begin
      mem_next[i] = mem_reg[i];
      if (wa_en && (wa_addr == MEM_AW'(i)))
      begin
        mem_next[i] = wa_data;
      end
      if (wb_en && (wb_addr == MEM_AW'(i)))
      begin
        mem_next[i] = wb_data;
      end
    end
    always_ff @(posedge core_clk_i)
    begin
      if (reset_i)
      begin
        mem_reg[i] <= `DTU_ZERO_BYTE;
      end
      else
      begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  assign acc_o       = acc_reg;
  assign flags_o     = flags_reg;
  assign busy_o      = busy_reg;
  assign done_o      = done_reg;
  assign io_wr_o     = io_reg;
  assign tmr_wr_o    = tmr_reg;
  assign peek_data_o = peek_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  imm_load_a: assert property ( // RQ1
    take && instr_i.op == DTU_OP_LD_IMM
    |=> acc_o == $past(instr_i.arg) && flags_o == $past(flags_o))
    else $error("immediate load wrong");

  mem_store_a: assert property ( // RQ2
    take && instr_i.op == DTU_OP_ST_MEM
    |=> mem_reg[$past(instr_i.arg[MEM_AW-1:0])] == $past(acc_o)
        && $stable(flags_o))
    else $error("memory store wrong");

  mem_load_a: assert property ( // RQ3
    take && instr_i.op == DTU_OP_LD_MEM
    |=> acc_o == $past(mem_reg[instr_i.arg[MEM_AW-1:0]])
        && flags_o.z == (acc_o == 8'h00)
        && {flags_o.c, flags_o.ac, flags_o.ov}
           == $past({flags_o.c, flags_o.ac, flags_o.ov}))
    else $error("memory load wrong");

  io_load_a: assert property ( // RQ4
    take && instr_i.op == DTU_OP_LD_IO
    |=> acc_o == $past(io_rdata_i) && flags_o.z == (acc_o == 8'h00)
        && {flags_o.c, flags_o.ac, flags_o.ov}
           == $past({flags_o.c, flags_o.ac, flags_o.ov}))
    else $error("io load wrong");

  io_store_a: assert property ( // RQ5
    take && instr_i.op == DTU_OP_ST_IO
    |=> io_wr_o.we && io_wr_o.data == $past(acc_o)
        && io_wr_o.addr == $past(instr_i.arg[`DTU_IO_AW-1:0])
        && $stable(flags_o)
    ##1 !io_wr_o.we || $past(take && instr_i.op == DTU_OP_ST_IO))
    else $error("io store wrong");

  timer_read_a: assert property ( // RQ6
    take && instr_i.op == DTU_OP_TMR_RD
    |=> {mem_reg[$past(word_hi)], mem_reg[$past(word_lo)]}
        == $past(timer_count_i) && $stable(flags_o))
    else $error("timer read wrong");

  timer_write_a: assert property ( // RQ7
    take && instr_i.op == DTU_OP_TMR_WR
    |=> tmr_wr_o.load
        && tmr_wr_o.value == $past({mem_reg[word_hi], mem_reg[word_lo]}))
    else $error("timer write wrong");

  indirect_rd_a: assert property ( // RQ8
    take && instr_i.op == DTU_OP_IND_RD
    |=> busy_o && !done_o && ptr_reg == $past(mem_reg[word_lo])
    ##1 !busy_o && done_o && acc_o == $past(mem_reg[ptr_reg])
        && $stable(flags_o))
    else $error("indirect read wrong");

  word_span_a: assert property ( // RQ11
    take && instr_i.op == DTU_OP_TMR_RD
    |-> wb_addr < `DTU_WORD_SPAN && !wa_addr[0]
        && wb_addr == wa_addr + 1'b1)
    else $error("word operand out of span");

  one_cycle_a: assert property ( // RQ13
    take && instr_i.op != DTU_OP_IND_RD |=> done_o && !busy_o)
    else $error("transfer not single cycle");

  ind_cov: cover property (take && instr_i.op == DTU_OP_IND_RD ##2 done_o);
  zero_cov: cover property (take && instr_i.op == DTU_OP_LD_MEM ##1 flags_o.z);
  tmr_cov: cover property (take && instr_i.op == DTU_OP_TMR_WR);
  io_cov: cover property (take && instr_i.op == DTU_OP_ST_IO);

endmodule

// [dtu_io_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////
module dtu_io_model
(
  input  wire logic           core_clk_i,
  input  wire logic           reset_i,
  input  wire logic [5:0]     addr_i,
  input  dtu_pkg::dtu_io_wr_t  io_wr_i,
  input  dtu_pkg::dtu_tmr_wr_t tmr_wr_i,
  output logic [7:0]          io_rdata_o,
  output logic [15:0]         count_o
);
  import dtu_pkg::*;
  logic [7:0] regs [64];
  // i/o space answers the addressed register at once;
  // a store still in flight is seen by the next load
  assign io_rdata_o = (io_wr_i.we && io_wr_i.addr == addr_i)
                      ? io_wr_i.data : regs[addr_i];
  // timer free-runs, reloads on a word load
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      regs    <= '{default: 8'h00};
      count_o <= 16'h0000;
    end
    else
    begin
      if (io_wr_i.we)
        regs[io_wr_i.addr] <= io_wr_i.data;
      count_o <= tmr_wr_i.load ? tmr_wr_i.value : count_o + 16'h0001;
    end
  end
endmodule

// [dtu_core_bench.sv]
`timescale 1ns/1ps
module dtu_core_bench;
  import dtu_pkg::*;
  logic        core_clk_i, reset_i, busy_o, done_o;
  dtu_instr_t  instr_i;
  logic [7:0]  io_rdata_i, peek_addr_i, acc_o, peek_data_o, acc;
  logic [15:0] timer_count_i;
  dtu_flags_t  flags_o;
  dtu_io_wr_t  io_wr_o;
  dtu_tmr_wr_t tmr_wr_o;
  logic [31:0] seed;
  logic [7:0]  sh [256];
  logic [7:0]  sio [64];
  logic        z;
  int          error_cnt, num_checks, cyc;

  dtu_core uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .instr_i(instr_i), .io_rdata_i(io_rdata_i),
    .timer_count_i(timer_count_i), .peek_addr_i(peek_addr_i),
    .acc_o(acc_o), .flags_o(flags_o), .busy_o(busy_o), .done_o(done_o),
    .io_wr_o(io_wr_o), .tmr_wr_o(tmr_wr_o), .peek_data_o(peek_data_o));
  dtu_io_model io_m (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .addr_i(instr_i.arg[5:0]), .io_wr_i(io_wr_o), .tmr_wr_i(tmr_wr_o),
    .io_rdata_o(io_rdata_i), .count_o(timer_count_i));
////////////////////////////////////////
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // one instruction, expectations from the bench shadow state
  task automatic run(input logic [3:0] op, input logic [7:0] arg);
    logic [15:0] cnt;
    logic [15:0] tv;
    logic [7:0]  a;
    instr_i = {1'b1, op, arg};
    cnt = timer_count_i;
    tv = {sh[{arg[3:0], 1'b1}], sh[{arg[3:0], 1'b0}]};
    a = acc;
    case (op)
      4'h1: acc = arg;
      4'h2: sh[arg] = acc;
      4'h3, 4'h4:
      begin
        acc = (op == 4'h3) ? sh[arg] : sio[arg[5:0]];
        z   = (acc == 8'h00);
      end
      4'h5: sio[arg[5:0]] = acc;
      4'h6: {sh[{arg[3:0], 1'b1}], sh[{arg[3:0], 1'b0}]} = cnt;
      4'h8: acc = sh[sh[{arg[3:0], 1'b0}]];
      default: ;
    endcase
    @(negedge core_clk_i);
    if (op == 4'h8)
    begin
      instr_i.op = DTU_OP_LD_IMM;
      chk("busy_done", 2'b10, {busy_o, done_o});
      @(negedge core_clk_i);
    end
    chk("done", 1'b1, done_o);
    chk("acc", acc, acc_o);
    chk("flags", {z, 3'b000}, flags_o);
    chk("io_we", op == 4'h5, io_wr_o.we);
    if (op == 4'h5)
      chk("io_wr", {arg[5:0], a}, {io_wr_o.addr, io_wr_o.data});
    chk("tmr_load", op == 4'h7, tmr_wr_o.load);
    if (op == 4'h7)
      chk("tmr_value", tv, tmr_wr_o.value);
  endtask

  task automatic sweep();
    instr_i.valid = 1'b0;
    peek_addr_i = 8'h00;
    for (int i = 0; i < 256; i++)
    begin
      @(negedge core_clk_i);
      chk("mem", sh[i], peek_data_o);
      peek_addr_i = 8'(i + 1);
    end
  endtask
////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    seed = 32'h6fc3;
    reset_i = 1'b1;
    instr_i = '0;
    peek_addr_i = 8'h00;
    acc = 8'h00;
    z = 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    foreach (sio[i]) sio[i] = 8'h00;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("reset", 0, {acc_o, flags_o, busy_o, done_o});
    reset_i = 1'b0;
    // pointer built low byte first, high byte zero
    run(4'h1, 8'h5b);
    run(4'h2, 8'h06);
    run(4'h1, 8'h00);
    run(4'h2, 8'h07);
    run(4'h3, 8'h07);
    run(4'h1, 8'ha5);
    run(4'h2, 8'h5b);
    run(4'h1, 8'h00);
    run(4'h8, 8'h03);
    run(4'h4, 8'h05);
    run(4'h5, 8'h05);
    run(4'h4, 8'h05);
    // timer word at the top of the word space
    run(4'h1, 8'h34);
    run(4'h2, 8'h1e);
    run(4'h1, 8'h12);
    run(4'h2, 8'h1f);
    run(4'h7, 8'h0f);
    run(4'h6, 8'h0f);
    for (int k = 0; k < 16; k++)
    begin
      seed = xs(seed);
      run(4'(k), seed[7:0]);
    end
    for (int k = 0; k < 300; k++)
    begin
      seed = xs(seed);
      run(seed[3:0], seed[11:4]);
    end
    sweep();
    summarize();
  end
endmodule
